// File: logic/utxb_pkg.sv
package utxb_pkg;
    // register offsets
    localparam logic [1:0] UTXB_ADDR_DATA   = 2'h0;
    localparam logic [1:0] UTXB_ADDR_STATUS = 2'h1;
    localparam logic [1:0] UTXB_ADDR_CTRL   = 2'h2;
    localparam logic [1:0] UTXB_ADDR_FMT    = 2'h3;
    // status_register_a fields
    localparam int UTXB_ST_PERR  = 2;
    localparam int UTXB_ST_OVR   = 3;
    localparam int UTXB_ST_FERR  = 4;
    localparam int UTXB_ST_EMPTY = 5;
    localparam int UTXB_ST_TXC   = 6;
    localparam int UTXB_ST_RXC   = 7;
    // control_register_b fields
    localparam int UTXB_CT_TX9   = 0;
    localparam int UTXB_CT_RX9   = 1;
    localparam int UTXB_CT_TX_ENABLE_BIT  = 3;
    localparam int UTXB_CT_RXEN  = 4;
    localparam int UTXB_CT_EMPIE = 5;
    localparam int UTXB_CT_TXCIE = 6;
    // format register fields
    localparam int UTXB_FM_SIZE  = 0;
    localparam int UTXB_FM_PODD  = 3;
    localparam int UTXB_FM_PEN   = 4;
    localparam int UTXB_FM_STOP2 = 5;
    localparam int UTXB_FM_SYNC  = 6;
    localparam logic [2:0] UTXB_SIZE_NINE = 3'h7;
    localparam logic [7:0] UTXB_CTRL_RST  = 8'h00;
    localparam logic [7:0] UTXB_FMT_RST   = 8'h06;
    localparam int UTXB_FIFO_DEPTH = 2;
    localparam int UTXB_BAUD_DIV   = 16;
    typedef enum logic [1:0] {
        UTXB_TX_IDLE  = 2'b00,
        UTXB_TX_SHIFT = 2'b01,
        UTXB_TX_STOP  = 2'b11
    } utxb_tx_state_t;
    typedef enum logic [1:0] {
        UTXB_RX_IDLE = 2'b00,
        UTXB_RX_BITS = 2'b01,
        UTXB_RX_STOP = 2'b11
    } utxb_rx_state_t;
endpackage

// File: logic/utxb_rx_fifo.sv
`timescale 1ns/1ps
module utxb_rx_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             rdEn,
    output logic      [WIDTH-1:0] rdData_r,
    output logic                  full_r,
    output logic                  empty_r
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             doWr;
    logic             doRd;
    logic [AW-1:0]    rdNext;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign doRd   = rdEn && !empty_r;
    assign doWr   = wrEn && (!full_r || doRd);
    assign rdNext = doRd ? bump(rdPtr_r) : rdPtr_r;

    always_comb begin
        count_nxt = count_r;
        if (doWr && !doRd) begin
            count_nxt = count_r + 1'b1;
        end else if (doRd && !doWr) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= wrData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || flush) begin
            wrPtr_r  <= '0;
            rdPtr_r  <= '0;
            count_r  <= '0;
            full_r   <= 1'b0;
            empty_r  <= 1'b1;
            rdData_r <= '0;
        end else begin
            wrPtr_r <= doWr ? bump(wrPtr_r) : wrPtr_r;
            rdPtr_r <= rdNext;
            count_r <= count_nxt;
            full_r  <= (count_nxt == (AW+1)'(DEPTH));
            empty_r <= (count_nxt == '0);
            // head word registered; write-through when empty
            if (count_nxt == '0) begin
                rdData_r <= '0;
            end else if (doWr && (count_r == '0 ||
                         (doRd && count_r == 1))) begin
                rdData_r <= wrData;
            end else begin
                rdData_r <= mem[rdNext];
            end
        end
    end
endmodule

// File: logic/utxb_uart.sv
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] nine-bit characters carry a ninth bit both ways for protocol use
// [R2] buffer-empty flag is set while the transmit buffer holds nothing
// [R3] software writes zero to the buffer-empty position of the status reg
// [R4] empty interrupt is flag and enable and global enable, as a level
// [R5] writing the data register clears buffer-empty; handler must refill
// [R6] complete flag sets when frame is out and buffer is empty
// [R7] complete flag clears on interrupt taken or on writing one
// [R8] complete interrupt raised while complete flag and its enable are set; the code also requires global enable
// [R9] parity over data bits inserted after last data bit before stop
// [R10] transmit disable waits until shift register and buffer are empty
// [R11] receive enable makes receiver own the serial input pin
// [R12] synchronous mode takes bit timing from the external clock pin
// [R13] receiver shifts bits to first stop bit, ignores a second one
// [R14] at first stop bit the frame moves into the receive buffer
// [R15] short characters read back with zeroed upper bits
// [R16] fifo stores ninth bit and error flags; data read advances it
// [R17] software reads status and ninth bit before the data register
// [R18] data read frees its fifo slot at once
// [R19] software writes the ninth transmit bit before the low byte
// [R20] shift register loads when idle or right after last stop bit
// [R21] two-character buffer; start bit while full and waiting sets overrun
// [R22] receive-complete follows unread data; disable flushes the buffer
module utxb_uart
    import utxb_pkg::*;
#(
    parameter int BAUD_DIV = UTXB_BAUD_DIV
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [1:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata_r,
    input  wire logic       globalIrqEn,
    input  wire logic       txcIrqAck,
    output logic            emptyIrq_r,
    output logic            txcIrq_r,
    input  wire logic       serialInPin,
    input  wire logic       extSyncClockPin,
    output logic            serialOut_r,
    output logic            serialOutOe_r,
    output logic            rxPinOwned_r
);
    localparam int DW = $clog2(BAUD_DIV);
    logic [7:0] ctrl_r;
    logic [7:0] fmt_r;
    logic [2:0] rxSync_r;
    logic [2:0] xckSync_r;
    logic       bitTick;
    logic [DW-1:0] baudCnt_r;
    logic [2:0] charSize;
    logic [3:0] dataBits;
    logic       dataWr;
    logic       dataRd;

    assign charSize = fmt_r[UTXB_FM_SIZE +: 3];
    assign dataBits = (charSize == UTXB_SIZE_NINE) ? 4'h9 :
                      (charSize > 3'h3) ? 4'h8 : {1'b0, charSize} + 4'h5;
    assign dataWr = regWr && regAddr == UTXB_ADDR_DATA;
    assign dataRd = regRd && regAddr == UTXB_ADDR_DATA;

    function automatic logic parity9(input logic [8:0] d,
                                     input logic [3:0] n,
                                     input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

    // data lsb first, then parity, ones above for the stop bits
    function automatic logic [10:0] txFrame(input logic [8:0] d,
                                           input logic [3:0] n,
                                           input logic       pen,
                                           input logic       odd);
        logic [10:0] f;
        f = '1;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                f[i] = d[i];
            end
        end
        if (pen) begin
            f[n] = parity9(d, n, odd);
        end
        return f;
    endfunction

    // pin synchronisers; stage 0 read only by stage 1
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxSync_r  <= 3'h7;
            xckSync_r <= 3'h0;
        end else begin
            rxSync_r  <= {rxSync_r[1:0], serialInPin};
            xckSync_r <= {xckSync_r[1:0], extSyncClockPin};
        end
    end

    // bit timing: internal divider or external clock edge
    always_ff @(posedge ref_clk) begin
        if (srst || baudCnt_r == DW'(BAUD_DIV - 1)) begin
            baudCnt_r <= '0;
        end else begin
            baudCnt_r <= baudCnt_r + 1'b1;
        end
    end
    assign bitTick = fmt_r[UTXB_FM_SYNC] ?
                     (xckSync_r[1] && !xckSync_r[2]) : // R12
                     (baudCnt_r == DW'(BAUD_DIV - 1));

    // ---------------- transmitter ----------------
    utxb_tx_state_t txState_r;
    logic [8:0] txBuf_r;
    logic       txBufFull_r;
    logic [10:0] txShift_r;
    logic [3:0] txCnt_r;
    logic       txcFlag_r;
    logic       txLoad;
    logic       txLastStop;
    logic       txActive;

    assign txLastStop = txState_r == UTXB_TX_STOP && bitTick && txCnt_r == 0;
    assign txActive   = ctrl_r[UTXB_CT_TX_ENABLE_BIT] || txBufFull_r ||
                        txState_r != UTXB_TX_IDLE; // R10
    assign txLoad = txBufFull_r && bitTick &&
                    (txState_r == UTXB_TX_IDLE || txLastStop); // R20

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txBuf_r     <= '0;
            txBufFull_r <= 1'b0;
        end else if (dataWr && ctrl_r[UTXB_CT_TX_ENABLE_BIT]) begin
            txBuf_r     <= {ctrl_r[UTXB_CT_TX9], regWdata}; // R1 R19
            txBufFull_r <= 1'b1; // R5
        end else if (txLoad) begin
            txBufFull_r <= 1'b0; // R2
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txState_r <= UTXB_TX_IDLE;
            txShift_r <= '1;
            txCnt_r   <= '0;
        end else if (txLoad) begin
            // data then parity then stop ones, lsb first after start
            txState_r <= UTXB_TX_SHIFT;
            txShift_r <= txFrame(txBuf_r, dataBits, fmt_r[UTXB_FM_PEN],
                                 fmt_r[UTXB_FM_PODD]); // R9
            txCnt_r   <= dataBits + {3'h0, fmt_r[UTXB_FM_PEN]};
        end else if (bitTick) begin
            case (txState_r)
                UTXB_TX_SHIFT: begin
                    txShift_r <= {1'b1, txShift_r[10:1]};
                    if (txCnt_r == 0) begin
                        txState_r <= UTXB_TX_STOP;
                        txCnt_r   <= {3'h0, fmt_r[UTXB_FM_STOP2]};
                    end else begin
                        txCnt_r <= txCnt_r - 1'b1;
                    end
                end
                UTXB_TX_STOP: begin
                    if (txCnt_r == 0) begin
                        txState_r <= UTXB_TX_IDLE;
                    end else begin
                        txCnt_r <= txCnt_r - 1'b1;
                    end
                end
                default: txState_r <= UTXB_TX_IDLE;
            endcase
        end
    end

    // serial output: start bit while loading, then shift lsb
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            serialOut_r   <= 1'b1;
            serialOutOe_r <= 1'b0;
        end else begin
            serialOutOe_r <= txActive; // R10
            if (txLoad) begin
                serialOut_r <= 1'b0;
            end else if (bitTick) begin
                serialOut_r <= txState_r == UTXB_TX_SHIFT ?
                               txShift_r[0] : 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            txcFlag_r <= 1'b0;
        end else if (txLastStop && !txLoad) begin
            txcFlag_r <= 1'b1; // R6
        end else if (txcIrqAck || (regWr && regAddr == UTXB_ADDR_STATUS &&
                     regWdata[UTXB_ST_TXC])) begin
            txcFlag_r <= 1'b0; // R7
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            emptyIrq_r <= 1'b0;
            txcIrq_r   <= 1'b0;
        end else begin
            emptyIrq_r <= !txBufFull_r && ctrl_r[UTXB_CT_EMPIE] &&
                          globalIrqEn; // R4
            txcIrq_r   <= txcFlag_r && ctrl_r[UTXB_CT_TXCIE] &&
                          globalIrqEn; // R8
        end
    end

    // ---------------- receiver ----------------
    utxb_rx_state_t rxState_r;
    logic [8:0] rxShift_r;
    logic       rxPar_r;
    logic [3:0] rxCnt_r;
    logic       rxWaiting_r;
    logic       ovr_r;
    logic [11:0] rxWord;
    logic [11:0] fifoHead;
    logic       fifoFull;
    logic       fifoEmpty;
    logic       rxPush;
    logic       rxIn;
    logic       rxEn;

    assign rxEn   = ctrl_r[UTXB_CT_RXEN];
    assign rxIn   = rxEn ? rxSync_r[2] : 1'b1; // R11
    assign rxPush = rxWaiting_r && !fifoFull;

    always_ff @(posedge ref_clk) begin
        if (srst || !rxEn) begin
            rxState_r <= UTXB_RX_IDLE;
            rxShift_r <= '0;
            rxPar_r   <= 1'b0;
            rxCnt_r   <= '0;
        end else if (bitTick) begin
            case (rxState_r)
                UTXB_RX_IDLE: begin
                    if (!rxIn) begin
                        rxState_r <= UTXB_RX_BITS;
                        rxShift_r <= '0;
                        rxCnt_r   <= '0;
                    end
                end
                UTXB_RX_BITS: begin
                    if (rxCnt_r < dataBits) begin
                        rxShift_r[rxCnt_r] <= rxIn; // R13
                    end else begin
                        rxPar_r <= rxIn;
                    end
                    rxCnt_r <= rxCnt_r + 1'b1;
                    if (rxCnt_r == dataBits - {3'h0,
                                  !fmt_r[UTXB_FM_PEN]}) begin
                        rxState_r <= UTXB_RX_STOP;
                    end
                end
                // second stop bit not awaited
                UTXB_RX_STOP: rxState_r <= UTXB_RX_IDLE; // R13
                default: rxState_r <= UTXB_RX_IDLE;
            endcase
        end
    end

    logic rxStop;
    assign rxStop = bitTick && rxState_r == UTXB_RX_STOP;

    always_ff @(posedge ref_clk) begin
        if (srst || !rxEn) begin
            rxWaiting_r <= 1'b0;
            rxWord      <= '0;
        end else if (rxStop) begin
            rxWaiting_r <= 1'b1; // R14
            rxWord <= {fmt_r[UTXB_FM_PEN] &&
                       parity9(rxShift_r, dataBits, fmt_r[UTXB_FM_PODD]) !=
                       rxPar_r,
                       !rxIn, 1'b0, rxShift_r};
        end else if (rxPush) begin
            rxWaiting_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !rxEn) begin
            ovr_r <= 1'b0;
        end else if (bitTick && rxState_r == UTXB_RX_IDLE && !rxIn &&
                     fifoFull && rxWaiting_r) begin
            ovr_r <= 1'b1; // R21
        end else if (rxPush) begin
            ovr_r <= 1'b0;
        end
    end

    utxb_rx_fifo #(
        .WIDTH (12),
        .DEPTH (UTXB_FIFO_DEPTH)
    ) uFifo (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .flush    (!rxEn), // R22
        .wrEn     (rxPush),
        .wrData   ({rxWord[11:10], ovr_r, rxWord[8:0]}), // R16
        .rdEn     (dataRd), // R18
        .rdData_r (fifoHead),
        .full_r   (fifoFull),
        .empty_r  (fifoEmpty)
    );

    // ---------------- registers ----------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_r <= UTXB_CTRL_RST;
            fmt_r  <= UTXB_FMT_RST;
        end else if (regWr && regAddr == UTXB_ADDR_CTRL) begin
            ctrl_r <= regWdata & 8'h79;
        end else if (regWr && regAddr == UTXB_ADDR_FMT) begin
            fmt_r <= regWdata & 8'h7f;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rxPinOwned_r <= 1'b0;
        end else begin
            rxPinOwned_r <= rxEn; // R11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regRdata_r <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                // upper bits masked for short characters
                UTXB_ADDR_DATA:
                    regRdata_r <= fifoHead[7:0] &
                                  ~(8'hff << dataBits); // R15
                UTXB_ADDR_STATUS:
                    regRdata_r <= {!fifoEmpty, txcFlag_r, !txBufFull_r,
                                   fifoHead[10], fifoHead[9],
                                   fifoHead[11], 2'h0}; // R2 R16 R22
                UTXB_ADDR_CTRL:
                    regRdata_r <= (ctrl_r & 8'h79) |
                                  {6'h0, fifoHead[8], 1'b0}; // R1
                UTXB_ADDR_FMT: regRdata_r <= fmt_r;
                default: regRdata_r <= 8'h00;
            endcase
        end else begin
            regRdata_r <= 8'h00;
        end
    end

    empty_irq_a: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 (emptyIrq_r == $past(!txBufFull_r && ctrl_r[UTXB_CT_EMPIE]
                                 && globalIrqEn)))
        else $error("empty irq mismatch"); // R4
    wr_clears_a: assert property (@(posedge ref_clk) disable iff (srst)
        dataWr && ctrl_r[UTXB_CT_TX_ENABLE_BIT] |=> txBufFull_r)
        else $error("write did not fill buffer"); // R5
    txc_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        txLastStop && !txLoad |=> txcFlag_r)
        else $error("complete flag not set"); // R6
    txc_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        txcIrqAck && !txLastStop |=> !txcFlag_r)
        else $error("complete flag not cleared"); // R7
    tx_disable_a: assert property (@(posedge ref_clk) disable iff (srst)
        txBufFull_r |=> serialOutOe_r)
        else $error("driver released with pending data"); // R10
    rx_own_a: assert property (@(posedge ref_clk) disable iff (srst)
        !rxEn |=> rxState_r == UTXB_RX_IDLE && !rxPinOwned_r)
        else $error("receiver active while disabled"); // R11
    rx_flush_a: assert property (@(posedge ref_clk) disable iff (srst)
        !rxEn |=> fifoEmpty)
        else $error("fifo not flushed"); // R22
    rx_move_a: assert property (@(posedge ref_clk) disable iff (srst)
        rxStop && rxEn |=> rxWaiting_r)
        else $error("frame not moved"); // R14
    short_mask_a: assert property (@(posedge ref_clk) disable iff (srst)
        regRd && regAddr == UTXB_ADDR_DATA && charSize == 3'h0
        |=> regRdata_r[7:5] == 3'h0)
        else $error("upper bits not masked"); // R15
    tx_frame_c: cover property (@(posedge ref_clk) txLastStop);
    rx_frame_c: cover property (@(posedge ref_clk) rxPush);
    ovr_c: cover property (@(posedge ref_clk) ovr_r);
endmodule

// File: test/utxb_peer.sv
`timescale 1ns/1ps
module utxb_peer #(
    parameter int BAUD = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        txLine,
    input  wire logic [3:0]  frameLen,
    output logic             rxLine,
    output logic      [11:0] gotFrame,
    output int               gotCount
);
    // remote receiver, samples each bit in its middle
    initial begin
        rxLine = 1'b1;
        gotCount = 0;
        forever begin
            @(negedge txLine);
            gotFrame = 12'h000;
            repeat (BAUD / 2) @(posedge ref_clk);
            for (int i = 0; i < int'(frameLen); i++) begin
                repeat (BAUD) @(posedge ref_clk);
                gotFrame[i] = txLine;
            end
            gotCount++;
        end
    end

    // remote sender, bits lsb first after a low start bit
    task automatic send(input logic [11:0] bits, input int len);
        rxLine <= 1'b0;
        repeat (BAUD) @(posedge ref_clk);
        for (int i = 0; i < len; i++) begin
            rxLine <= bits[i];
            repeat (BAUD) @(posedge ref_clk);
        end
        rxLine <= 1'b1;
        repeat (BAUD) @(posedge ref_clk);
    endtask
endmodule

// File: test/tb_utxb_uart.sv
`timescale 1ns/1ps
module tb_utxb_uart
    import utxb_pkg::*;
();
    localparam int BAUD = 8;
    logic        ref_clk;
    logic        srst;
    logic [1:0]  regAddr;
    logic [7:0]  regWdata;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdata_r;
    logic        globalIrqEn;
    logic        txcIrqAck;
    logic        emptyIrq_r;
    logic        txcIrq_r;
    logic        serialInPin;
    logic        xck;
    logic        serialOut_r;
    logic        serialOutOe_r;
    logic        rxPinOwned_r;
    logic [3:0]  frameLen;
    logic [11:0] gotFrame;
    int          gotCount;
    int          mismatches;
    int          checked;
    // released line is pulled high
    wire         txLine = serialOutOe_r ? serialOut_r : 1'b1;
    // format, ninth bit and data
    logic [16:0] rows [7] = '{{8'h23, 9'h0a5}, {8'h00, 9'h1ff},
        {8'h01, 9'h02a}, {8'h12, 9'h053}, {8'h1b, 9'h0a5},
        {8'h07, 9'h1c3}, {8'h17, 9'h0f0}};

    utxb_uart #(.BAUD_DIV(BAUD)) DUT (
        .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata_r(regRdata_r), .globalIrqEn(globalIrqEn),
        .txcIrqAck(txcIrqAck), .emptyIrq_r(emptyIrq_r),
        .txcIrq_r(txcIrq_r), .serialInPin(serialInPin),
        .extSyncClockPin(xck), .serialOut_r(serialOut_r),
        .serialOutOe_r(serialOutOe_r), .rxPinOwned_r(rxPinOwned_r)
    );
    utxb_peer #(.BAUD(BAUD)) peer (
        .ref_clk(ref_clk), .txLine(txLine), .frameLen(frameLen),
        .rxLine(serialInPin), .gotFrame(gotFrame), .gotCount(gotCount)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // external bit clock, one period per bit
    initial begin
        xck = 1'b0;
        forever begin
            repeat (BAUD / 2) @(posedge ref_clk);
            xck <= ~xck;
        end
    end

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] seen,
                       input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata_r;
    endtask

    task automatic waitRxc(output logic [7:0] s);
        for (int i = 0; i < 40; i++) begin
            rd(UTXB_ADDR_STATUS, s);
            if (s[UTXB_ST_RXC] === 1'b1)
                break;
        end
    endtask

    task automatic waitPeer(input int c);
        for (int i = 0; i < 4000 && gotCount < c; i++)
            @(posedge ref_clk);
        chk("frames seen", 12'(gotCount), 12'(c));
    endtask

    function automatic int mkFrame(input logic [8:0] d, input logic [7:0] f,
                                   input logic [1:0] bad,
                                   output logic [11:0] b,
                                   output logic [8:0] md);
        int n;
        n = (f[2:0] == UTXB_SIZE_NINE) ? 9 : int'(f[1:0]) + 5;
        md = d & 9'((1 << n) - 1);
        b = {3'h0, md};
        if (f[UTXB_FM_PEN]) begin
            b[n] = ^md ^ f[UTXB_FM_PODD] ^ bad[0];
            n++;
        end
        b[n] = ~bad[1];
        return n + 1;
    endfunction

    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end

    initial begin
        logic [11:0] fb;
        logic [8:0]  md;
        logic [7:0]  s;
        logic        ovr;
        int          n;
        int          c;
        srst = 1'b1;
        regAddr = 2'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        globalIrqEn = 1'b0;
        txcIrqAck = 1'b0;
        frameLen = 4'h9;
        mismatches = 0;
        checked = 0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            n = mkFrame(rows[i][8:0], rows[i][16:9], 2'b00, fb, md);
            frameLen <= 4'(n);
            wr(UTXB_ADDR_FMT, rows[i][16:9]);
            wr(UTXB_ADDR_CTRL, {7'h0c, rows[i][8]});
            c = gotCount;
            wr(UTXB_ADDR_DATA, rows[i][7:0]);
            waitPeer(c + 1);
            chk("tx frame", gotFrame, fb);
            peer.send(fb, n);
            waitRxc(s);
            chk("rx status", 12'(s & 8'h9c), 12'h080);
            rd(UTXB_ADDR_CTRL, s);
            chk("rx ninth", 12'(s[UTXB_CT_RX9]), 12'(md[8]));
            rd(UTXB_ADDR_DATA, s);
            chk("rx data", 12'(s), 12'(md[7:0]));
            rd(UTXB_ADDR_STATUS, s);
            chk("rx drained", 12'(s[UTXB_ST_RXC]), 12'h000);
        end
        // transmitter flags, interrupts and deferred disable
        wr(UTXB_ADDR_FMT, 8'h03);
        frameLen <= 4'h9;
        rd(UTXB_ADDR_STATUS, s);
        chk("txc set", 12'(s[UTXB_ST_TXC]), 12'h001);
        globalIrqEn <= 1'b1;
        wr(UTXB_ADDR_CTRL, 8'h78);
        @(posedge ref_clk);
        #1;
        chk("irqs on", 12'({emptyIrq_r, txcIrq_r}), 12'h003);
        @(posedge ref_clk);
        txcIrqAck <= 1'b1;
        @(posedge ref_clk);
        txcIrqAck <= 1'b0;
        rd(UTXB_ADDR_STATUS, s);
        chk("txc by ack", 12'(s[UTXB_ST_TXC]), 12'h000);
        c = gotCount;
        wr(UTXB_ADDR_DATA, 8'h11);
        // a second write once the buffer has emptied is held while the first frame shifts
        s = 8'h00;
        for (int i = 0; i < 20 && !s[UTXB_ST_EMPTY]; i++)
            rd(UTXB_ADDR_STATUS, s);
        wr(UTXB_ADDR_DATA, 8'h22);
        rd(UTXB_ADDR_STATUS, s);
        chk("buffer held", 12'(s & 8'h60), 12'h000);
        chk("empty irq off", 12'(emptyIrq_r), 12'h000);
        wr(UTXB_ADDR_CTRL, 8'h70);
        chk("tx oe held", 12'(serialOutOe_r), 12'h001);
        waitPeer(c + 2);
        chk("second frame", gotFrame, 12'h122);
        repeat (BAUD + 4) @(posedge ref_clk);
        #1;
        chk("tx released",
            12'({serialOutOe_r, emptyIrq_r, txcIrq_r}), 12'h003);
        @(posedge ref_clk);
        globalIrqEn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irqs masked", 12'({emptyIrq_r, txcIrq_r}), 12'h000);
        wr(UTXB_ADDR_STATUS, 8'h40);
        rd(UTXB_ADDR_STATUS, s);
        chk("txc by write", 12'(s & 8'h60), 12'h020);
        // receive errors and overrun, even parity
        wr(UTXB_ADDR_FMT, 8'h13);
        wr(UTXB_ADDR_CTRL, 8'h10);
        for (int k = 0; k < 4; k++) begin
            // bad stop on the first, bad parity on the second
            n = mkFrame(9'(8'h5a + 8'(k)), 8'h13, 2'(8'h06 >> (2 * k)),
                        fb, md);
            peer.send(fb, n);
        end
        chk("rx owns pin", 12'(rxPinOwned_r), 12'h001);
        rd(UTXB_ADDR_STATUS, s);
        chk("stop error", 12'(s & 8'h9c), 12'h090);
        rd(UTXB_ADDR_DATA, s);
        chk("first data", 12'(s), 12'h05a);
        rd(UTXB_ADDR_STATUS, s);
        chk("parity error", 12'(s & 8'h9c), 12'h084);
        rd(UTXB_ADDR_DATA, s);
        chk("second data", 12'(s), 12'h05b);
        ovr = 1'b0;
        repeat (2) begin
            rd(UTXB_ADDR_STATUS, s);
            ovr = ovr | s[UTXB_ST_OVR];
            rd(UTXB_ADDR_DATA, s);
        end
        chk("overrun", 12'(ovr), 12'h001);
        peer.send(fb, n);
        waitRxc(s);
        wr(UTXB_ADDR_CTRL, 8'h00);
        rd(UTXB_ADDR_STATUS, s);
        chk("flushed", 12'({s[UTXB_ST_RXC], rxPinOwned_r}), 12'h000);
        wr(UTXB_ADDR_FMT, 8'h43);
        wr(UTXB_ADDR_CTRL, 8'h08);
        c = gotCount;
        wr(UTXB_ADDR_DATA, 8'h3c);
        waitPeer(c + 1);
        chk("sync frame", gotFrame, 12'h13c);
        // second reset in mid-run
        wr(UTXB_ADDR_CTRL, 8'h18);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(UTXB_ADDR_STATUS, s);
        chk("status reset", 12'(s), 12'h020);
        rd(UTXB_ADDR_CTRL, s);
        chk("ctrl reset", 12'(s), 12'(UTXB_CTRL_RST));
        rd(UTXB_ADDR_FMT, s);
        chk("fmt reset", 12'(s), 12'(UTXB_FMT_RST));
        @(posedge ref_clk);
        #1;
        chk("pins reset", {serialOut_r, serialOutOe_r, rxPinOwned_r,
            emptyIrq_r, txcIrq_r, |regRdata_r}, 12'h020);
        conclude();
    end
endmodule
